// [hdl/ffs_ms_tick.sv]
// Millisecond tick generator, restartable so a timed interval starts cleanly.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
module ffs_ms_tick #(
    parameter int CYCLES = 100000
) (
    input  wire logic i_core_clk,
    input  wire logic i_rst_n,
    input  wire logic i_restart,
    output logic      o_tick
);
    logic [16:0] cnt_reg;
    logic [16:0] cnt_next;
    logic        tick_reg;
    logic        tick_next;

    always_comb begin
        tick_next = 1'b0;
        cnt_next  = cnt_reg + 17'h00001;
        if (i_restart) begin
            cnt_next = 17'h00000;
        end else if (cnt_reg == 17'(CYCLES - 1)) begin
            cnt_next  = 17'h00000;
            tick_next = 1'b1;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            cnt_reg  <= 17'h00000;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign o_tick = tick_reg;
endmodule

// [hdl/ffs_params.svh]
// Constants of the forced-stop base-cut sequencer: offsets, fields, resets, timing.
// Assumes inclusion by bare name from design files.
`ifndef FFS_PARAMS_SVH
`define FFS_PARAMS_SVH

`define FFS_CLK_PERIOD_NS   10
`define FFS_MS_NS           1000000
`define FFS_MS_CYCLES       (`FFS_MS_NS / `FFS_CLK_PERIOD_NS)

`define FFS_ADDR_W          8
`define FFS_OFS_CTRL        8'h00
`define FFS_OFS_DELAY       8'h04
`define FFS_OFS_DECEL       8'h08
`define FFS_OFS_ZERO        8'h0c
`define FFS_OFS_COMP        8'h10
`define FFS_OFS_STATUS      8'h14
`define FFS_OFS_SPEED       8'h18
`define FFS_OFS_IRQ_STAT    8'h1c
`define FFS_OFS_IRQ_MASK    8'h20

`define FFS_SEL_ENABLE      4'h2
`define FFS_SEL_DISABLE     4'h0
`define FFS_ALARM_STO_CODE  8'h63

`define FFS_RST_SEL         4'h2
`define FFS_RST_TORQUE      1'b0
`define FFS_RST_DELAY_EN    1'b1
`define FFS_RST_DELAY_MS    16'h0000
`define FFS_RST_DECEL_MS    16'h0000
`define FFS_RST_ZERO        16'h0032
`define FFS_RST_COMP        16'h0000
`define FFS_RATED_SPEED     16'h0bb8

`define FFS_IRQ_W           4
`define FFS_IRQ_STOP        0
`define FFS_IRQ_CUT         1
`define FFS_IRQ_ALARM       2
`define FFS_IRQ_CLEAR       3

`endif

// [hdl/ffs_pkg.sv]
// Types of the forced-stop base-cut sequencer.
// Assumes nothing of its surroundings.
package ffs_pkg;

    typedef enum logic [2:0] {
        FFS_RUN   = 3'b000,
        FFS_DECEL = 3'b001,
        FFS_DELAY = 3'b010,
        FFS_CUT   = 3'b011
    } ffs_state_t;

    typedef struct packed {
        logic [3:0]  stop_function_select;
        logic        torque_mode;
        logic        delay_enable;
        logic [15:0] base_cut_delay_setting;
        logic [15:0] forced_stop_decel_constant;
        logic [15:0] zero_speed_threshold;
        logic [15:0] freefall_comp_amount;
    } ffs_cfg_t;

    typedef struct packed {
        logic        base_drive;
        logic        brake_interlock_output;
        logic        dynamic_brake;
        logic        lift_active;
    } ffs_drive_t;

endpackage

// [hdl/ffs_ramp.sv]
// Internal model speed command: follows the external command, or ramps to zero.
// Assumes a millisecond tick; the constant is ms from rated speed to zero.
`timescale 1ns/10ps
`include "ffs_params.svh"
module ffs_ramp (
    input  wire logic        i_core_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_follow,
    input  wire logic [15:0] i_ext_cmd,
    input  wire logic        i_tick,
    input  wire logic [15:0] i_decel_ms,
    output logic [15:0]      o_speed
);
    logic [15:0] speed_reg;
    logic [15:0] speed_next;
    logic [31:0] acc_reg;
    logic [31:0] acc_next;

    // Error accumulator spreads rated speed over the constant without a divider
    always_comb begin
        speed_next = speed_reg;
        acc_next   = acc_reg;
        if (i_follow) begin
            speed_next = i_ext_cmd;
            acc_next   = 32'h00000000;
        end else if (i_decel_ms == 16'h0000 || speed_reg == 16'h0000) begin
            speed_next = 16'h0000;
            acc_next   = 32'h00000000;
        end else begin
            if (acc_reg >= {16'h0000, i_decel_ms}) begin
                acc_next   = acc_reg - {16'h0000, i_decel_ms};
                speed_next = speed_reg - 16'h0001;
            end
            if (i_tick) begin
                acc_next = acc_next + {16'h0000, `FFS_RATED_SPEED};
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            speed_reg <= 16'h0000;
            acc_reg   <= 32'h00000000;
        end else begin
            speed_reg <= speed_next;
            acc_reg   <= acc_next;
        end
    end

    assign o_speed = speed_reg;
endmodule

// [hdl/ffs_top.sv]
// Forced-stop base-cut sequencer: decel ramp, brake interlock, base-cut delay,
// freefall lift, alarm latch and clear, register port with interrupt.
// Assumes all inputs synchronous to i_core_clk; control power cycle is i_rst_n.
`timescale 1ns/10ps
`include "ffs_params.svh"
module ffs_top #(
    parameter int MS_CYCLES = `FFS_MS_CYCLES
) (
    input  wire logic                   i_core_clk,
    input  wire logic                   i_rst_n,
    input  wire logic [`FFS_ADDR_W-1:0] i_addr,
    input  wire logic [31:0]            i_wr_data,
    input  wire logic                   i_wr_en,
    input  wire logic                   i_rd_en,
    output logic [31:0]                 o_rd_data,
    input  wire logic                   i_servo_on,
    input  wire logic                   i_forced_stop_two_input,
    input  wire logic                   i_safe_torque_removal_input,
    input  wire logic                   i_alarm_reset_input,
    input  wire logic                   i_set_button,
    input  wire logic                   i_alarm_event,
    input  wire logic [7:0]             i_alarm_code,
    input  wire logic                   i_alarm_dyn_brake,
    input  wire logic                   i_alarm_cause_present,
    input  wire logic [15:0]            i_motor_speed,
    input  wire logic [15:0]            i_ext_speed_cmd,
    output logic [15:0]                 o_speed_cmd,
    output logic                        o_base_drive,
    output logic                        o_brake_interlock_output,
    output logic                        o_dynamic_brake,
    output logic                        o_lift_active,
    output logic [15:0]                 o_lift_distance,
    output logic                        o_fault_output,
    output logic                        o_irq
);
    ffs_pkg::ffs_cfg_t    cfg_reg;
    ffs_pkg::ffs_cfg_t    cfg_next;
    logic [`FFS_IRQ_W-1:0] irq_stat_reg;
    logic [`FFS_IRQ_W-1:0] irq_stat_next;
    logic [`FFS_IRQ_W-1:0] irq_mask_reg;
    logic [`FFS_IRQ_W-1:0] irq_mask_next;
    logic [`FFS_IRQ_W-1:0] irq_evt;
    logic [31:0]          rd_data_reg;
    logic [31:0]          rd_data_next;
    logic                 irq_reg;
    logic                 irq_next;

    ffs_pkg::ffs_state_t  state_reg;
    ffs_pkg::ffs_state_t  state_next;
    ffs_pkg::ffs_drive_t  drive_reg;
    ffs_pkg::ffs_drive_t  drive_next;
    logic [15:0]          delay_cnt_reg;
    logic [15:0]          delay_cnt_next;
    logic                 lift_arm_reg;
    logic                 lift_arm_next;

    logic                 alarm_reg;
    logic                 alarm_next;
    logic [7:0]           alarm_code_reg;
    logic [7:0]           alarm_code_next;
    logic                 rst_in_prev_reg;
    logic                 sto_prev_reg;

    logic                 decel_en;
    logic                 alarm_raise;
    logic [7:0]           raise_code;
    logic                 raise_db;
    logic                 cause_now;
    logic                 clear_req;
    logic                 sto_fall;
    logic                 below_zero;
    logic                 ms_tick;
    logic                 ramp_follow;
    logic [15:0]          ramp_speed;

    // Decel availability depends on select digit and control mode
    assign decel_en = (cfg_reg.stop_function_select == `FFS_SEL_ENABLE)
                      && !cfg_reg.torque_mode;
    assign sto_fall   = sto_prev_reg && !i_safe_torque_removal_input;
    assign below_zero = i_motor_speed < cfg_reg.zero_speed_threshold;

    // Only the first alarm is latched; a later one keeps the first code
    always_comb begin
        raise_code  = i_alarm_code;
        raise_db    = i_alarm_dyn_brake;
        alarm_raise = 1'b0;
        if (state_reg == ffs_pkg::FFS_DECEL && sto_fall) begin
            raise_code  = `FFS_ALARM_STO_CODE;
            raise_db    = 1'b1;
            alarm_raise = !alarm_reg;
        end else if (i_alarm_event) begin
            alarm_raise = !alarm_reg;
        end
    end

    assign cause_now = i_alarm_cause_present
                       || (alarm_code_reg == `FFS_ALARM_STO_CODE
                           && !i_safe_torque_removal_input);
    assign clear_req = i_set_button
                       || (i_alarm_reset_input && !rst_in_prev_reg);

    always_comb begin
        alarm_next      = alarm_reg;
        alarm_code_next = alarm_code_reg;
        if (alarm_reg && clear_req && !cause_now) begin
            alarm_next      = 1'b0;
            alarm_code_next = 8'h00;
        end
        if (alarm_raise) begin
            alarm_next      = 1'b1;
            alarm_code_next = raise_code;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            alarm_reg       <= 1'b0;
            alarm_code_reg  <= 8'h00;
            rst_in_prev_reg <= 1'b0;
            sto_prev_reg    <= 1'b1;
        end else begin
            alarm_reg       <= alarm_next;
            alarm_code_reg  <= alarm_code_next;
            rst_in_prev_reg <= i_alarm_reset_input;
            sto_prev_reg    <= i_safe_torque_removal_input;
        end
    end

    // Stop sequence
    always_comb begin
        state_next     = state_reg;
        delay_cnt_next = delay_cnt_reg;
        lift_arm_next  = lift_arm_reg;
        case (state_reg)
            ffs_pkg::FFS_RUN: begin
                lift_arm_next = 1'b0;
                if (alarm_raise || alarm_reg || !i_forced_stop_two_input) begin
                    if (!decel_en || (alarm_raise && raise_db)) begin
                        state_next = ffs_pkg::FFS_CUT;
                    end else begin
                        state_next = ffs_pkg::FFS_DECEL;
                    end
                end
            end
            ffs_pkg::FFS_DECEL: begin
                if (alarm_raise && raise_db) begin
                    state_next = ffs_pkg::FFS_CUT;
                end else if (below_zero) begin
                    // Lift only for a slowdown that this sequence caused
                    lift_arm_next = (cfg_reg.freefall_comp_amount != 16'h0000)
                                    && cfg_reg.delay_enable;
                    delay_cnt_next = 16'h0000;
                    state_next = cfg_reg.delay_enable ? ffs_pkg::FFS_DELAY
                                                      : ffs_pkg::FFS_CUT;
                end
            end
            ffs_pkg::FFS_DELAY: begin
                if (alarm_raise && raise_db) begin
                    state_next = ffs_pkg::FFS_CUT;
                end else if (delay_cnt_reg >= cfg_reg.base_cut_delay_setting) begin
                    state_next = ffs_pkg::FFS_CUT;
                end else if (ms_tick) begin
                    delay_cnt_next = delay_cnt_reg + 16'h0001;
                end
            end
            ffs_pkg::FFS_CUT: begin
                lift_arm_next = 1'b0;
                if (i_servo_on && i_forced_stop_two_input && !alarm_reg && !alarm_raise) begin
                    state_next = ffs_pkg::FFS_RUN;
                end
            end
            default: begin
                state_next = ffs_pkg::FFS_CUT;
            end
        endcase
    end

    // Outputs are decoded from the next state so they leave straight from flops
    always_comb begin
        drive_next = '0;
        case (state_next)
            ffs_pkg::FFS_RUN: begin
                drive_next.base_drive             = 1'b1;
                drive_next.brake_interlock_output = 1'b1;
            end
            ffs_pkg::FFS_DECEL: begin
                drive_next.base_drive             = 1'b1;
                drive_next.brake_interlock_output = 1'b1;
            end
            ffs_pkg::FFS_DELAY: begin
                drive_next.base_drive  = 1'b1;
                drive_next.lift_active = lift_arm_next;
            end
            ffs_pkg::FFS_CUT: begin
                drive_next.dynamic_brake = 1'b1;
            end
            default: begin
                drive_next.dynamic_brake = 1'b1;
            end
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            state_reg     <= ffs_pkg::FFS_CUT;
            drive_reg     <= 4'b0010;
            delay_cnt_reg <= 16'h0000;
            lift_arm_reg  <= 1'b0;
        end else begin
            state_reg     <= state_next;
            drive_reg     <= drive_next;
            delay_cnt_reg <= delay_cnt_next;
            lift_arm_reg  <= lift_arm_next;
        end
    end

    // Tick restarts when decel reaches zero speed so the first delay ms is a whole one
    ffs_ms_tick #(
        .CYCLES     (MS_CYCLES)
    ) u_tick (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_restart  (state_reg == ffs_pkg::FFS_DECEL && below_zero),
        .o_tick     (ms_tick)
    );

    assign ramp_follow = (state_reg == ffs_pkg::FFS_RUN);

    ffs_ramp u_ramp (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_follow   (ramp_follow),
        .i_ext_cmd  (i_ext_speed_cmd),
        .i_tick     (ms_tick),
        .i_decel_ms (cfg_reg.forced_stop_decel_constant),
        .o_speed    (ramp_speed)
    );

    // Register port and interrupt
    assign irq_evt = {alarm_reg && !alarm_next,
                      alarm_raise,
                      state_reg != ffs_pkg::FFS_CUT && state_next == ffs_pkg::FFS_CUT,
                      state_reg == ffs_pkg::FFS_RUN && state_next == ffs_pkg::FFS_DECEL};

    always_comb begin
        cfg_next      = cfg_reg;
        irq_mask_next = irq_mask_reg;
        irq_stat_next = irq_stat_reg;
        rd_data_next  = 32'h00000000;
        if (i_wr_en) begin
            case (i_addr)
                `FFS_OFS_CTRL: begin
                    cfg_next.stop_function_select = i_wr_data[3:0];
                    cfg_next.torque_mode          = i_wr_data[4];
                    cfg_next.delay_enable         = i_wr_data[5];
                end
                `FFS_OFS_DELAY:    cfg_next.base_cut_delay_setting     = i_wr_data[15:0];
                `FFS_OFS_DECEL:    cfg_next.forced_stop_decel_constant = i_wr_data[15:0];
                `FFS_OFS_ZERO:     cfg_next.zero_speed_threshold       = i_wr_data[15:0];
                `FFS_OFS_COMP:     cfg_next.freefall_comp_amount       = i_wr_data[15:0];
                `FFS_OFS_IRQ_STAT: irq_stat_next = irq_stat_reg & ~i_wr_data[`FFS_IRQ_W-1:0];
                `FFS_OFS_IRQ_MASK: irq_mask_next = i_wr_data[`FFS_IRQ_W-1:0];
                default: begin
                end
            endcase
        end
        // A new event wins over a clear in the same cycle
        irq_stat_next = irq_stat_next | irq_evt;
        if (i_rd_en) begin
            case (i_addr)
                `FFS_OFS_CTRL:     rd_data_next = {26'h0000000, cfg_reg.delay_enable,
                                                   cfg_reg.torque_mode,
                                                   cfg_reg.stop_function_select};
                `FFS_OFS_DELAY:    rd_data_next = {16'h0000, cfg_reg.base_cut_delay_setting};
                `FFS_OFS_DECEL:    rd_data_next = {16'h0000, cfg_reg.forced_stop_decel_constant};
                `FFS_OFS_ZERO:     rd_data_next = {16'h0000, cfg_reg.zero_speed_threshold};
                `FFS_OFS_COMP:     rd_data_next = {16'h0000, cfg_reg.freefall_comp_amount};
                `FFS_OFS_STATUS:   rd_data_next = {16'h0000, alarm_code_reg, 3'h0,
                                                   alarm_reg, drive_reg.lift_active,
                                                   state_reg};
                `FFS_OFS_SPEED:    rd_data_next = {16'h0000, ramp_speed};
                `FFS_OFS_IRQ_STAT: rd_data_next = {28'h0000000, irq_stat_reg};
                `FFS_OFS_IRQ_MASK: rd_data_next = {28'h0000000, irq_mask_reg};
                default:           rd_data_next = 32'h00000000;
            endcase
        end
        irq_next = |(irq_stat_next & irq_mask_next);
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            cfg_reg.stop_function_select       <= `FFS_RST_SEL;
            cfg_reg.torque_mode                <= `FFS_RST_TORQUE;
            cfg_reg.delay_enable               <= `FFS_RST_DELAY_EN;
            cfg_reg.base_cut_delay_setting     <= `FFS_RST_DELAY_MS;
            cfg_reg.forced_stop_decel_constant <= `FFS_RST_DECEL_MS;
            cfg_reg.zero_speed_threshold       <= `FFS_RST_ZERO;
            cfg_reg.freefall_comp_amount       <= `FFS_RST_COMP;
            irq_stat_reg                       <= 4'h0;
            irq_mask_reg                       <= 4'h0;
            rd_data_reg                        <= 32'h00000000;
            irq_reg                            <= 1'b0;
        end else begin
            cfg_reg      <= cfg_next;
            irq_stat_reg <= irq_stat_next;
            irq_mask_reg <= irq_mask_next;
            rd_data_reg  <= rd_data_next;
            irq_reg      <= irq_next;
        end
    end

    assign o_rd_data                = rd_data_reg;
    assign o_speed_cmd              = ramp_speed;
    assign o_base_drive             = drive_reg.base_drive;
    assign o_brake_interlock_output = drive_reg.brake_interlock_output;
    assign o_dynamic_brake          = drive_reg.dynamic_brake;
    assign o_lift_active            = drive_reg.lift_active;
    assign o_lift_distance          = lift_arm_reg ? cfg_reg.freefall_comp_amount : 16'h0000;
    assign o_fault_output           = alarm_reg;
    assign o_irq                    = irq_reg;
endmodule

// [test/ffs_monitor.sv]
// Port checker of the stop sequencer, bound into its top module.
// Assumes one clock and the synchronous active-low reset.
`timescale 1ns/10ps
module ffs_monitor #(
    parameter int MS_CYCLES = 100000
) (
    input wire logic        i_core_clk,
    input wire logic        i_rst_n,
    input wire logic        i_rd_en,
    input wire logic [31:0] o_rd_data,
    input wire logic        i_forced_stop_two_input,
    input wire logic        i_safe_torque_removal_input,
    input wire logic        i_set_button,
    input wire logic        i_alarm_event,
    input wire logic        i_alarm_dyn_brake,
    input wire logic        i_alarm_cause_present,
    input wire logic        o_base_drive,
    input wire logic        o_brake_interlock_output,
    input wire logic        o_dynamic_brake,
    input wire logic        o_lift_active,
    input wire logic [15:0] o_lift_distance,
    input wire logic        o_fault_output
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    AST_BRAKE_BASE: assert property (o_brake_interlock_output |-> o_base_drive)
        else $error("brake released without base drive");
    AST_LIFT: assert property (
        o_lift_active |-> o_base_drive && !o_brake_interlock_output && o_lift_distance != 0)
        else $error("lift without base or amount");
    // Two samples of forced stop low with base and brake on can only be the ramp
    AST_STO_ALARM: assert property (
        $fell(i_safe_torque_removal_input) && !i_forced_stop_two_input
        && !$past(i_forced_stop_two_input) && o_base_drive && o_brake_interlock_output
        && !o_fault_output |=> o_fault_output && !o_base_drive)
        else $error("no alarm on torque removal in decel");
    AST_LATCH: assert property (i_alarm_event |=> o_fault_output)
        else $error("alarm not latched");
    AST_DB_ALARM: assert property (
        i_alarm_event && i_alarm_dyn_brake |=> !o_base_drive && o_dynamic_brake)
        else $error("dynamic brake alarm did not cut base");
    AST_CAUSE: assert property (o_fault_output && i_alarm_cause_present |=> o_fault_output)
        else $error("alarm cleared with cause present");
    AST_CLEAR: assert property (
        o_fault_output && i_set_button && !i_alarm_cause_present && !i_alarm_event
        && i_safe_torque_removal_input |-> ##[1:2] !o_fault_output)
        else $error("alarm not cleared by set button");
    AST_RD_IDLE: assert property (!i_rd_en |=> o_rd_data == 32'h0)
        else $error("read data outside read cycle");
    cover property (o_lift_active);
    cover property (o_fault_output ##1 !o_fault_output);
    cover property ($fell(o_base_drive) && o_dynamic_brake);
endmodule
bind ffs_top ffs_monitor #(.MS_CYCLES(MS_CYCLES)) mon_u (.i_core_clk, .i_rst_n, .i_rd_en,
    .o_rd_data, .i_forced_stop_two_input, .i_safe_torque_removal_input, .i_set_button,
    .i_alarm_event, .i_alarm_dyn_brake, .i_alarm_cause_present, .o_base_drive,
    .o_brake_interlock_output, .o_dynamic_brake, .o_lift_active, .o_lift_distance,
    .o_fault_output);

// [test/ffs_motor_model.sv]
// Motor and power stage model driven by the sequencer's outputs.
// Assumes the sequencer's clock and reset.
`timescale 1ns/10ps
module ffs_motor_model (
    input  wire logic        i_core_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_slow,
    input  wire logic        i_base_drive,
    input  wire logic [15:0] i_speed_cmd,
    output logic      [15:0] o_motor_speed
);
    logic phase_reg;
    // Slow mode follows only every other cycle, so the zero-speed check sees lag
    always_ff @(posedge i_core_clk) begin
        phase_reg <= ~phase_reg & i_rst_n;
        if (!i_rst_n)
            o_motor_speed <= 16'h0;
        else if (i_base_drive && !(i_slow && phase_reg))
            o_motor_speed <= i_speed_cmd;
        else if (!i_base_drive)
            o_motor_speed <= (o_motor_speed > 16'h20) ? o_motor_speed - 16'h20 : 16'h0;
    end
endmodule

// [test/ffs_top_tb.sv]
// Bench of the stop sequencer: random drive, stop, alarm and clear cases.
// Assumes the sequencer, its monitor and the motor model are compiled first.
`timescale 1ns/10ps
`include "ffs_params.svh"
module ffs_top_tb;
    localparam int MS = 10;
    logic        clk, rst_n, wr, rd, son, fs, safe_torque_removal_input, ares, setb, aev, adb, acause, slow;
    logic        base, brk, db, lift, fault, irq;
    logic [7:0]  addr, acode;
    logic [15:0] mspd, ext, cmd, ldist;
    logic [31:0] wdat, rdat, v;
    logic [31:0] ctl [3] = '{32'h22, 32'h20, 32'h32};
    logic [39:0] rtab [7] = '{40'h00_00000022, 40'h04_00000000, 40'h0c_00000032,
        40'h10_00000000, 40'h14_00000003, 40'h20_00000000, 40'h24_00000000};
    int          errors, n_compared, n, d;
    ffs_top #(.MS_CYCLES(MS)) dut_u (.i_core_clk(clk), .i_rst_n(rst_n), .i_addr(addr),
        .i_wr_data(wdat), .i_wr_en(wr), .i_rd_en(rd), .o_rd_data(rdat), .i_servo_on(son),
        .i_forced_stop_two_input(fs), .i_safe_torque_removal_input(safe_torque_removal_input),
        .i_alarm_reset_input(ares), .i_set_button(setb), .i_alarm_event(aev),
        .i_alarm_code(acode), .i_alarm_dyn_brake(adb), .i_alarm_cause_present(acause),
        .i_motor_speed(mspd), .i_ext_speed_cmd(ext), .o_speed_cmd(cmd), .o_base_drive(base),
        .o_brake_interlock_output(brk), .o_dynamic_brake(db), .o_lift_active(lift),
        .o_lift_distance(ldist), .o_fault_output(fault), .o_irq(irq));
    ffs_motor_model motor_u (.i_core_clk(clk), .i_rst_n(rst_n), .i_slow(slow),
        .i_base_drive(base), .i_speed_cmd(cmd), .o_motor_speed(mspd));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] x);
        @(posedge clk);
        {addr, wdat, wr} <= {a, x, 1'b1};
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a);
        @(posedge clk);
        {addr, rd} <= {a, 1'b1};
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdat;
    endtask
    task automatic clear_req(input int how, input logic cause);
        @(posedge clk);
        {acause, setb, ares} <= {cause, how == 0, how != 0};
        @(posedge clk);
        {setb, ares} <= 2'b00;
        repeat (3) @(negedge clk);
    endtask
    task automatic wait_st(input logic [2:0] s);
        for (int k = 0; k < 2000; k++) begin
            rreg(8'h14);
            if (v[2:0] === s)
                return;
        end
        chk("state", {29'h0, s}, v);
        give_verdict();
    endtask
    task automatic give_verdict;
        $display("compared %0d wrong %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        {rst_n, wr, rd, son, ares, setb, aev, adb, acause, slow, fs, safe_torque_removal_input} = 12'h003;
        {addr, acode, ext, wdat, errors, n_compared} = '0;
        void'($urandom(67));
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        wreg(8'h14, 32'hff);
        foreach (rtab[i]) begin
            rreg(rtab[i][39:32]);
            chk("reset value", rtab[i][31:0], v);
        end
        $display("register test done");
        wreg(8'h20, 32'h4);
        for (int i = 0; i < 3; i++) begin
            d = $urandom_range(4, 1);
            wreg(8'h00, ctl[i]);
            wreg(8'h04, d);
            wreg(8'h08, $urandom_range(3, 1));
            wreg(8'h10, 32'h5);
            @(posedge clk);
            {son, fs, slow, ext} <= {2'b11, 1'($urandom), 16'($urandom_range(3000, 200))};
            wait_st(ffs_pkg::FFS_RUN);
            @(posedge clk);
            fs <= 1'b0;
            rreg(8'h14);
            chk("stop state", (i == 0) ? 32'h1 : 32'h3, {29'h0, v[2:0]});
            if (i == 0) begin
                for (n = 0; n < 4000 && brk === 1'b1; n++)
                    @(negedge clk);
                chk("entry", 32'h4, {base, brk, irq});
                chk("lift", 32'h7, {lift, ldist == 16'h5, cmd <= 16'h32});
                for (n = 0; n < 2000 && base === 1'b1; n++)
                    @(negedge clk);
                chk("cut delay", 32'h1, n >= d * MS && n <= d * MS + 3);
                chk("dyn brake", 32'h1, db);
            end
            else
                chk("cut drive", 32'h1, {base, db});
            $display("stop test %0d done", i);
        end
        wreg(8'h00, 32'h22);
        wreg(8'h08, 32'h3);
        for (int j = 0; j < 2; j++) begin
            @(posedge clk);
            {fs, ext} <= {1'b1, 16'hbb8};
            wait_st(ffs_pkg::FFS_RUN);
            repeat (20) @(posedge clk);
            {aev, acause, acode} <= {2'b11, 8'($urandom)};
            @(posedge clk);
            {aev, ext} <= {1'b0, 16'h0c80};
            repeat (3) @(negedge clk);
            chk("alarm decel", 32'hf, {fault, base, cmd <= 16'hbb8, irq});
            wait_st(ffs_pkg::FFS_CUT);
            chk("alarm code", {24'h0, acode}, {24'h0, v[15:8]});
            clear_req(j, 1'b1);
            chk("fault kept", 32'h1, fault);
            clear_req(j, 1'b0);
            chk("fault cleared", 32'h0, fault);
            wreg(8'h1c, 32'hf);
            rreg(8'h1c);
            chk("irq cleared", 32'h0, {v[2], irq});
            $display("alarm test %0d done", j);
        end
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            fs <= 1'b1;
            wait_st(ffs_pkg::FFS_RUN);
            repeat (20) @(posedge clk);
            fs <= 1'b0;
            repeat (3) @(posedge clk);
            {aev, adb, safe_torque_removal_input} <= {k == 0, k == 0, k == 0};
            @(posedge clk);
            {aev, adb} <= 2'b00;
            repeat (2) @(negedge clk);
            rreg(8'h14);
            chk("db stop", {24'h1, (k == 0) ? acode : `FFS_ALARM_STO_CODE},
                {22'h0, base, db, v[15:8]});
            @(posedge clk);
            safe_torque_removal_input <= 1'b1;
            clear_req(0, 1'b0);
            $display("brake test %0d done", k);
        end
        give_verdict();
    end
endmodule
